// >>> ecs_defines.svh
`ifndef ECS_DEFINES_SVH
`define ECS_DEFINES_SVH

// register indices; byte address is four times the index
`define ECS_IDX_MAP_SIZE 8'h56
`define ECS_IDX_STRETCH 8'h5A
`define ECS_IDX_CHIP_SELECT_CONTROL 8'h5B
`define ECS_IDX_GP1_START 8'h5C
`define ECS_IDX_GP1_CTL 8'h5D
`define ECS_IDX_GP2_START 8'h5E
`define ECS_IDX_GP2_CTL 8'h5F

// reset values
`define ECS_RST_CHIP_SELECT_CONTROL 8'h04
`define ECS_RST_ZERO 8'h00

// write mask of registers with reserved bits
`define ECS_WMASK_MAP_SIZE 8'hC0
`define ECS_WMASK_GP2_CTL 8'hBF

// axi answers
`define ECS_RESP_OKAY 2'b00
`define ECS_RESP_SLVERR 2'b10

// program select size codes
`define ECS_PSZ_64K 2'b00
`define ECS_PSZ_32K 2'b01
`define ECS_PSZ_16K 2'b10
`define ECS_PSZ_8K 2'b11

// io select ranges, upper cpu address bits
`define ECS_IO4K_TOP 4'h1
`define ECS_IO8K_TOP 3'h0

// general select size codes
`define ECS_SZ_OFF 4'h0
`define ECS_SZ_2K 4'h1
`define ECS_SZ_4K 4'h2
`define ECS_SZ_512K 4'h9
`define ECS_SZ_WIN1 4'hA
`define ECS_SZ_WIN2 4'hB
`define ECS_CPU_MASK 8'h1F
`define ECS_FULL_MASK 8'hFF

// timing: e clock half period
`define ECS_CLK_NS 100
`define ECS_E_HALF_NS 200
`define ECS_E_HALF_CYC ((`ECS_E_HALF_NS + `ECS_CLK_NS - 1) / `ECS_CLK_NS)

`endif

// >>> ecs_pkg.sv
package ecs_pkg;

   typedef struct packed {
      logic io_select_enable;
      logic io_select_polarity;
      logic io_select_valid_phase;
      logic io_select_size;
      logic general_over_program_priority;
      logic program_select_enable;
      logic program_size_high;
      logic program_size_low;
   } ecs_chip_select_control_t;

   typedef struct packed {
      logic onto_program;
      logic onto_two;
      logic polarity;
      logic valid_phase;
      logic [3:0] size_code;
   } ecs_gpctl_t;

   typedef struct packed {
      logic [1:0] io_stretch;
      logic [1:0] gp1_stretch;
      logic [1:0] gp2_stretch;
      logic [1:0] prog_stretch;
   } ecs_stretch_t;

   typedef struct packed {
      logic general_two_address_source;
      logic general_one_address_source;
      logic [5:0] unused;
   } ecs_mapsize_t;

   typedef enum logic [2:0] {
      ECS_E_LOW = 3'b001,
      ECS_E_HIGH = 3'b010,
      ECS_E_HOLD = 3'b100
   } ecs_e_state_t;

endpackage

// >>> ecs_gp_decode.sv
`timescale 1ns/1ps
`include "ecs_defines.svh"

module ecs_gp_decode (
   // addresses
   input wire logic [15:0] cpu_addr,
   input wire logic [18:0] exp_addr,
   input wire logic win1_hit,
   input wire logic win2_hit,
   // settings
   input wire logic addr_source,
   input wire logic [7:0] start_bits,
   input wire logic [3:0] size_code,
   // result
   output logic hit
);
   import ecs_pkg::*;

   logic [7:0] sel_addr;
   logic [3:0] eff_code;

   // mask of start bits compared for a size
   function automatic logic [7:0] cmp_mask(input logic [3:0] code, input logic src);
      logic [7:0] m;
      m = `ECS_FULL_MASK << (code - `ECS_SZ_2K);
      if (!src) begin
         m = m & `ECS_CPU_MASK;
         if (code == `ECS_SZ_4K) begin
            m = `ECS_CPU_MASK;
         end
      end
      return m;
   endfunction

   always_comb begin
      sel_addr = addr_source ? exp_addr[18:11] : {3'h0, cpu_addr[15:11]};
      eff_code = (size_code > `ECS_SZ_WIN2) ? `ECS_SZ_512K : size_code;
      case (size_code)
         `ECS_SZ_OFF: begin
            hit = 1'b0;
         end
         `ECS_SZ_WIN1: begin
            hit = win1_hit;
         end
         `ECS_SZ_WIN2: begin
            hit = win2_hit;
         end
         default: begin
            hit = ((sel_addr ^ start_bits) & cmp_mask(eff_code, addr_source)) == 8'h00;
         end
      endcase
   end

endmodule

// >>> ecs_eclk.sv
`timescale 1ns/1ps
`include "ecs_defines.svh"

module ecs_eclk (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // stretch request of current access
   input wire logic [1:0] stretch_cycles,
   // e clock and free timer tick
   output logic e_high_q,
   output logic timer_tick_q
);
   import ecs_pkg::*;

   localparam logic [3:0] HALF_LAST = 4'(`ECS_E_HALF_CYC - 1);

   logic [3:0] div_q;
   logic tick;
   logic [2:0] hold_q;
   ecs_e_state_t state_q;

   assign tick = (div_q == HALF_LAST);

   // divider runs regardless of stretch
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         div_q <= 4'h0;
      end else if (tick) begin
         div_q <= 4'h0;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         timer_tick_q <= 1'b0;
      end else begin
         timer_tick_q <= tick;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state_q <= ECS_E_LOW;
         e_high_q <= 1'b0;
         hold_q <= 3'h0;
      end else if (tick) begin
         case (state_q)
            ECS_E_LOW: begin
               state_q <= ECS_E_HIGH;
               e_high_q <= 1'b1;
            end
            ECS_E_HIGH: begin
               if (stretch_cycles != 2'b00) begin
                  state_q <= ECS_E_HOLD;
                  hold_q <= {stretch_cycles, 1'b0};
               end else begin
                  state_q <= ECS_E_LOW;
                  e_high_q <= 1'b0;
               end
            end
            ECS_E_HOLD: begin
               if (hold_q == 3'h1) begin
                  state_q <= ECS_E_LOW;
                  e_high_q <= 1'b0;
               end
               hold_q <= hold_q - 3'h1;
            end
            default: begin
               state_q <= ECS_E_LOW;
               e_high_q <= 1'b0;
            end
         endcase
      end
   end

endmodule

// >>> ecs_top.sv
// Functional notes
// - program select address-valid timed, active low
// - priority bit chooses program or general winner
// - program enable routes pin, set at reset
// - two size bits pick program range
// - io select off at reset, enable drives
// - io polarity bit, default active low
// - io valid phase: e high or address
// - io size: 4k at 0x1000 or 8k
// - zero to three stretch per select
// - source bit picks cpu or expansion address
// - general selects have own polarity bit
// - general selects have own valid phase
// - size code decode, zero disables
// - codes 1010/1011 follow expansion windows
// - compare only start bits size needs, all five for 4k on cpu address
// - eight start bits hold address 18:11
// - second general ORed onto program pin
// - all eight drive settings accepted
// - two bit stretch field, binary count
// - e held high, other clocks run
`timescale 1ns/1ps
`include "ecs_defines.svh"

module ecs_top (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // axi4-lite write address
   input wire logic [9:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // cpu bus
   input wire logic [15:0] cpu_addr,
   input wire logic [18:0] exp_addr,
   input wire logic addr_valid,
   input wire logic window_one_hit,
   input wire logic window_two_hit,
   // select pins
   output logic program_area_select_q,
   output logic io_area_select_q,
   output logic general_select_one_q,
   output logic general_select_two_q,
   // port h pin ownership
   output logic program_pin_owned_q,
   output logic io_pin_owned_q,
   // clocks
   output logic e_clock_q,
   output logic timer_tick_q
);
   import ecs_pkg::*;

   ecs_chip_select_control_t chip_select_control_q;
   ecs_gpctl_t gp1_ctl_q;
   ecs_gpctl_t gp2_ctl_q;
   ecs_stretch_t stretch_q;
   ecs_mapsize_t map_size_q;
   logic [7:0] gp1_start_q;
   logic [7:0] gp2_start_q;

   logic aw_taken_q;
   logic w_taken_q;
   logic [7:0] aw_idx_q;
   logic [7:0] wdata_q;
   logic wstrb_q;
   logic [7:0] rd_byte;
   logic rd_hit;
   logic [7:0] ar_idx;

   logic gp1_raw;
   logic gp2_raw;
   logic prog_raw;
   logic io_raw;
   logic gp1_win;
   logic gp2_win;
   logic prog_win;
   logic prog_pin;
   logic gp1_pin;
   logic gp2_pin;
   logic [1:0] stretch_d;

   // register index from byte address
   function automatic logic [7:0] reg_index(input logic [9:0] addr);
      return addr[9:2];
   endfunction

   function automatic logic is_mapped(input logic [7:0] idx);
      return (idx == `ECS_IDX_MAP_SIZE) || (idx == `ECS_IDX_STRETCH) ||
             (idx == `ECS_IDX_CHIP_SELECT_CONTROL) || (idx == `ECS_IDX_GP1_START) ||
             (idx == `ECS_IDX_GP1_CTL) || (idx == `ECS_IDX_GP2_START) ||
             (idx == `ECS_IDX_GP2_CTL);
   endfunction

   function automatic logic [1:0] max2(input logic [1:0] a, input logic [1:0] b);
      return (a > b) ? a : b;
   endfunction

   // write address channel
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         s_axi_awready <= 1'b0;
         aw_taken_q <= 1'b0;
         aw_idx_q <= 8'h00;
      end else begin
         s_axi_awready <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_taken_q <= 1'b1;
            aw_idx_q <= reg_index(s_axi_awaddr);
         end else if (s_axi_awvalid && !aw_taken_q && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            aw_taken_q <= 1'b0;
         end
      end
   end

   // write data channel
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         s_axi_wready <= 1'b0;
         w_taken_q <= 1'b0;
         wdata_q <= 8'h00;
         wstrb_q <= 1'b0;
      end else begin
         s_axi_wready <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) begin
            w_taken_q <= 1'b1;
            wdata_q <= s_axi_wdata[7:0];
            wstrb_q <= s_axi_wstrb[0];
         end else if (s_axi_wvalid && !w_taken_q && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            w_taken_q <= 1'b0;
         end
      end
   end

   // write response after both halves
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ECS_RESP_OKAY;
      end else if (s_axi_bvalid) begin
         if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end else if (aw_taken_q && w_taken_q) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= is_mapped(aw_idx_q) ? `ECS_RESP_OKAY : `ECS_RESP_SLVERR;
      end
   end

   // register writes, on the same edge that sets bvalid
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         chip_select_control_q <= `ECS_RST_CHIP_SELECT_CONTROL;
         gp1_ctl_q <= `ECS_RST_ZERO;
         gp2_ctl_q <= `ECS_RST_ZERO;
         stretch_q <= `ECS_RST_ZERO;
         map_size_q <= `ECS_RST_ZERO;
         gp1_start_q <= `ECS_RST_ZERO;
         gp2_start_q <= `ECS_RST_ZERO;
      end else if (aw_taken_q && w_taken_q && !s_axi_bvalid && wstrb_q) begin
         case (aw_idx_q)
            `ECS_IDX_CHIP_SELECT_CONTROL: begin
               chip_select_control_q <= wdata_q;
            end
            `ECS_IDX_GP1_CTL: begin
               gp1_ctl_q <= wdata_q;
            end
            `ECS_IDX_GP2_CTL: begin
               gp2_ctl_q <= wdata_q & `ECS_WMASK_GP2_CTL;
            end
            `ECS_IDX_STRETCH: begin
               stretch_q <= wdata_q;
            end
            `ECS_IDX_MAP_SIZE: begin
               map_size_q <= wdata_q & `ECS_WMASK_MAP_SIZE;
            end
            `ECS_IDX_GP1_START: begin
               gp1_start_q <= wdata_q;
            end
            `ECS_IDX_GP2_START: begin
               gp2_start_q <= wdata_q;
            end
            default: begin
               chip_select_control_q <= chip_select_control_q;
            end
         endcase
      end
   end

   // read data mux
   always_comb begin
      ar_idx = reg_index(s_axi_araddr);
      rd_hit = is_mapped(ar_idx);
      case (ar_idx)
         `ECS_IDX_CHIP_SELECT_CONTROL: rd_byte = chip_select_control_q;
         `ECS_IDX_GP1_CTL: rd_byte = gp1_ctl_q;
         `ECS_IDX_GP2_CTL: rd_byte = gp2_ctl_q;
         `ECS_IDX_STRETCH: rd_byte = stretch_q;
         `ECS_IDX_MAP_SIZE: rd_byte = map_size_q;
         `ECS_IDX_GP1_START: rd_byte = gp1_start_q;
         `ECS_IDX_GP2_START: rd_byte = gp2_start_q;
         default: rd_byte = 8'h00;
      endcase
   end

   // read channel
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `ECS_RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_rvalid) begin
            if (s_axi_rready) begin
               s_axi_rvalid <= 1'b0;
            end
         end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_hit ? `ECS_RESP_OKAY : `ECS_RESP_SLVERR;
         end else if (s_axi_arvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // general select range decoders
   ecs_gp_decode u_gp1 (
      .cpu_addr(cpu_addr),
      .exp_addr(exp_addr),
      .win1_hit(window_one_hit),
      .win2_hit(window_two_hit),
      .addr_source(map_size_q.general_one_address_source),
      .start_bits(gp1_start_q),
      .size_code(gp1_ctl_q.size_code),
      .hit(gp1_raw)
   );

   ecs_gp_decode u_gp2 (
      .cpu_addr(cpu_addr),
      .exp_addr(exp_addr),
      .win1_hit(window_one_hit),
      .win2_hit(window_two_hit),
      .addr_source(map_size_q.general_two_address_source),
      .start_bits(gp2_start_q),
      .size_code(gp2_ctl_q.size_code),
      .hit(gp2_raw)
   );

   // fixed range decoders
   always_comb begin
      case ({chip_select_control_q.program_size_high, chip_select_control_q.program_size_low})
         `ECS_PSZ_64K: prog_raw = 1'b1;
         `ECS_PSZ_32K: prog_raw = cpu_addr[15];
         `ECS_PSZ_16K: prog_raw = &cpu_addr[15:14];
         `ECS_PSZ_8K: prog_raw = &cpu_addr[15:13];
         default: prog_raw = 1'b0;
      endcase
      if (chip_select_control_q.io_select_size) begin
         io_raw = cpu_addr[15:13] == `ECS_IO8K_TOP;
      end else begin
         io_raw = cpu_addr[15:12] == `ECS_IO4K_TOP;
      end
   end

   // priority and phase qualification
   always_comb begin
      if (chip_select_control_q.general_over_program_priority) begin
         prog_win = prog_raw && !gp1_raw && !gp2_raw;
         gp1_win = gp1_raw;
         gp2_win = gp2_raw;
      end else begin
         prog_win = prog_raw && chip_select_control_q.program_select_enable;
         gp1_win = gp1_raw && !prog_win;
         gp2_win = gp2_raw && !prog_win;
      end
      // program valid for whole address time
      prog_win = prog_win && addr_valid;
      gp1_win = gp1_win && addr_valid && (gp1_ctl_q.valid_phase || e_clock_q);
      gp2_win = gp2_win && addr_valid && (gp2_ctl_q.valid_phase || e_clock_q);
      prog_pin = prog_win || (gp1_ctl_q.onto_program && gp1_win) ||
                 (gp2_ctl_q.onto_program && gp2_win);
      // routed select leaves own pin idle
      gp2_pin = !gp2_ctl_q.onto_program &&
                (gp2_win || (gp1_ctl_q.onto_two && gp1_win));
      gp1_pin = !gp1_ctl_q.onto_program && !gp1_ctl_q.onto_two && gp1_win;
   end

   // stretch of any select in range
   always_comb begin
      stretch_d = 2'b00;
      if (prog_raw && chip_select_control_q.program_select_enable) begin
         stretch_d = max2(stretch_d, stretch_q.prog_stretch);
      end
      if (io_raw && chip_select_control_q.io_select_enable) begin
         stretch_d = max2(stretch_d, stretch_q.io_stretch);
      end
      if (gp1_raw) begin
         stretch_d = max2(stretch_d, stretch_q.gp1_stretch);
      end
      if (gp2_raw) begin
         stretch_d = max2(stretch_d, stretch_q.gp2_stretch);
      end
      if (!addr_valid) begin
         stretch_d = 2'b00;
      end
   end

   // e clock with stretch
   ecs_eclk u_eclk (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .stretch_cycles(stretch_d),
      .e_high_q(e_clock_q),
      .timer_tick_q(timer_tick_q)
   );

   // select pin registers
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         program_area_select_q <= 1'b1;
         io_area_select_q <= 1'b1;
         general_select_one_q <= 1'b1;
         general_select_two_q <= 1'b1;
      end else begin
         program_area_select_q <= !(prog_pin && chip_select_control_q.program_select_enable);
         io_area_select_q <= chip_select_control_q.io_select_polarity ~^
                             (io_raw && addr_valid && chip_select_control_q.io_select_enable &&
                              (chip_select_control_q.io_select_valid_phase || e_clock_q));
         general_select_one_q <= gp1_ctl_q.polarity ~^ gp1_pin;
         general_select_two_q <= gp2_ctl_q.polarity ~^ gp2_pin;
      end
   end

   // port h pin ownership
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         program_pin_owned_q <= 1'b0;
         io_pin_owned_q <= 1'b0;
      end else begin
         // enable hands pin 7 to program select
         program_pin_owned_q <= chip_select_control_q.program_select_enable;
         // enable hands pin 4 to io select
         io_pin_owned_q <= chip_select_control_q.io_select_enable;
      end
   end

endmodule

// >>> ecs_mem_model.sv
`timescale 1ns/1ps
module ecs_mem_model (
   // select pins and their active levels
   input wire logic [3:0] pins,
   input wire logic [3:0] act_high,
   // device enables, high when selected
   output logic [3:0] sel
);
   // each device sees its select at the active level
   assign sel = ~(pins ^ act_high);
endmodule

// >>> ecs_top_properties.sv
`timescale 1ns/1ps
module ecs_top_properties (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   // pins and clocks
   input wire logic program_area_select_q,
   input wire logic program_pin_owned_q,
   input wire logic io_pin_owned_q,
   input wire logic e_clock_q,
   input wire logic timer_tick_q
);
   localparam int MAX_HIGH = 14;
   logic [4:0] e_high_q;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   // length of current e high phase
   always_ff @(posedge clk_sys) begin
      if (!rstn || !e_clock_q) begin
         e_high_q <= 5'h0;
      end else begin
         e_high_q <= e_high_q + 5'h1;
      end
   end
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence e_low_half;
      !e_clock_q ##1 e_clock_q;
   endsequence
   AST_PIN_RESET: assert property (disable iff (1'b0)
      !rstn ##1 rstn |=> program_pin_owned_q && !io_pin_owned_q)
      else $error("pin owners wrong after reset");
   AST_PROG_OFF: assert property (!program_pin_owned_q [*2] |-> program_area_select_q)
      else $error("program pin active while released");
   AST_E_LOW: assert property ($fell(e_clock_q) |=> e_low_half)
      else $error("e low half not two cycles");
   AST_STRETCH_MAX: assert property (e_high_q <= MAX_HIGH)
      else $error("e high too long");
   AST_TICK: assert property (timer_tick_q |=> !timer_tick_q ##1 timer_tick_q)
      else $error("timer tick rate broken");
   AST_WRITE_RESP: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   AST_READ_RESP: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
      else $error("read data late");
   AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
endmodule

// >>> ecs_top_test.sv
`timescale 1ns/1ps
module ecs_top_test;
   logic clk_sys = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic av = 0, w1 = 0, w2 = 0, h;
   logic awready, wready, bvalid, arready, rvalid, ps, ios, g1s, g2s, pown, iown, eclk, tick;
   logic [9:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [1:0] bresp, rresp;
   logic [15:0] a = 0;
   logic [18:0] x = 0;
   logic [3:0] seen;
   logic [7:0] rnd = 8'h0C, st, c, m;
   logic [7:0] idx [7] = '{8'h56, 8'h5A, 8'h5B, 8'h5C, 8'h5D, 8'h5E, 8'h5F};
   int n_errors = 0, n_checks = 0, cyc = 0, n;
   ecs_top DUT (.clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cpu_addr(a), .exp_addr(x), .addr_valid(av), .window_one_hit(w1), .window_two_hit(w2),
      .program_area_select_q(ps), .io_area_select_q(ios), .general_select_one_q(g1s),
      .general_select_two_q(g2s), .program_pin_owned_q(pown), .io_pin_owned_q(iown),
      .e_clock_q(eclk), .timer_tick_q(tick));
   ecs_mem_model u_mem (.pins({ps, g2s, g1s, ios}), .act_high(4'h0), .sel(seen));
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   function logic [7:0] lfsr(logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   function logic gp_hit(logic src, logic [7:0] s, logic [3:0] cd);
      int k;
      k = (cd == 2 && !src) ? 11 : 10 + cd;
      if (cd == 0) return 0;
      if (cd > 9) return cd == 10 ? w1 : cd == 11 ? w2 : 1;
      if (!src && k > 15) return 1;
      return src ? (x >> k) == ({s, 11'h0} >> k) : (a >> k) == ({s[4:0], 11'h0} >> k);
   endfunction
   function logic [2:0] drv(logic pri, logic [2:0] d);
      logic p, h1, h2;
      p = 1;
      h1 = a < 16'h0800;
      h2 = a[15:11] == 1;
      if (pri) p = !(h1 | h2);
      else {h1, h2} = 2'h0;
      return {p | d[1] & h1 | d[0] & h2, !d[0] & (h2 | d[2] & h1), !(d[2] | d[1]) & h1};
   endfunction
   task complete_run;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(string s, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", s, e, g);
      end
   endtask
   task wr(logic [7:0] i, logic [7:0] d, logic [1:0] er);
      @(posedge clk_sys);
      awaddr <= {i, 2'h0};
      wdata <= {24'h0, d};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge clk_sys);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (bvalid) bready <= 0;
      end while (!bvalid);
      chk("bresp", er, bresp);
   endtask
   task rd(logic [7:0] i, logic [7:0] d, logic [1:0] er);
      @(posedge clk_sys);
      araddr <= {i, 2'h0};
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge clk_sys);
         if (arready) arvalid <= 0;
         if (rvalid) rready <= 0;
      end while (!rvalid);
      chk("rresp", er, rresp);
      chk("rdata", d, rdata);
   endtask
   task cfg(logic [7:0] cs, g1c, g1a, g2c, g2a, mp, sr);
      wr(8'h5B, cs, 0);
      wr(8'h5D, g1c, 0);
      wr(8'h5C, g1a, 0);
      wr(8'h5F, g2c, 0);
      wr(8'h5E, g2a, 0);
      wr(8'h56, mp, 0);
      wr(8'h5A, sr, 0);
   endtask
   task put(logic [15:0] na, logic [18:0] nx, logic v);
      @(posedge clk_sys);
      a <= na;
      x <= nx;
      av <= v;
      repeat (2) @(posedge clk_sys);
   endtask
   task ph(logic lvl);
      @(posedge clk_sys);
      while (eclk !== lvl) @(posedge clk_sys);
      @(posedge clk_sys);
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         complete_run;
      end
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      rstn <= 1;
      repeat (2) @(posedge clk_sys);
      chk("owners", 2'h2, {pown, iown});
      foreach (idx[i]) begin
         m = idx[i] == 8'h56 ? 8'hC0 : idx[i] == 8'h5F ? 8'hBF : 8'hFF;
         rd(idx[i], idx[i] == 8'h5B ? 8'h04 : 8'h00, 0);
         rnd = lfsr(rnd);
         wr(idx[i], rnd, 0);
         rd(idx[i], rnd & m, 0);
      end
      wr(8'h50, 8'hFF, 2'h2);
      rd(8'h50, 8'h00, 2'h2);
      for (int k = 0; k < 5; k++) begin
         cfg(k < 4 ? 8'h04 | k[1:0] : 8'h00, 0, 0, 0, 0, 0, 0);
         chk("prog owner", k < 4, pown);
         for (int i = 0; i < 16; i++) begin
            put({i[2:0], 13'h0} - i[3], 0, 1);
            chk("prog pin", !(k < 4 && a[15:13] >= {k != 0, k[1], k == 3}), ps);
         end
         put(16'hFFFF, 0, 0);
         chk("prog idle", 1, ps);
      end
      for (int k = 0; k < 16; k++) begin
         cfg({k[3:0], 4'h4}, 0, 0, 0, 0, 0, 0);
         chk("io owner", k[3], iown);
         for (int i = 0; i < 4; i++) begin
            put(i == 2 ? 16'h1FFF : {2'h0, i[1:0], 12'h0}, 0, 1);
            h = k[3] && (k[0] ? a[15:13] == 0 : a[15:12] == 1);
            ph(1);
            chk("io high", !(h ^ k[2]), ios);
            ph(0);
            chk("io low", !(h & k[1] ^ k[2]), ios);
         end
      end
      for (int i = 0; i < 40; i++) begin
         rnd = lfsr(rnd);
         c = rnd;
         w1 <= rnd[6];
         w2 <= rnd[7];
         st = lfsr(rnd);
         rnd = lfsr(st);
         m = {2'h0, c[4], i[2], c[3:0]};
         if (i[0]) cfg(8'h0C, 0, 0, m, st, {c[5], 7'h0}, 0);
         else cfg(8'h0C, m, st, 0, 0, {1'b0, c[5], 6'h0}, 0);
         put(i[1] ? {st[4:0], rnd, 3'h0} : {rnd, st}, i[1] ? {st, rnd, 3'h0} : {st, st, 3'h5}, 1);
         h = gp_hit(c[5], st, c[3:0]);
         ph(1);
         chk("gp pins", i[0] ? {!(h ^ c[4]), 1'b1} : {1'b1, !(h ^ c[4])}, {g2s, g1s});
         chk("prog pin", h, ps);
         ph(0);
         h = h & i[2];
         chk("gp low", i[0] ? {!(h ^ c[4]), 1'b1} : {1'b1, !(h ^ c[4])}, {g2s, g1s});
      end
      for (int k = 0; k < 16; k++) begin
         cfg({4'h0, k[3], 3'h4}, {k[1], k[2], 6'h11}, 0, {k[0], 7'h11}, 8'h01, 0, 0);
         for (int i = 0; i < 3; i++) begin
            put({4'h0, i[0], 11'h0} | {i[1], 15'h0}, 0, 1);
            m = {5'h0, drv(k[3], k[2:0])};
            chk("routed pins", m, seen[3:1]);
         end
      end
      for (int k = 0; k < 4; k++) begin
         cfg(8'h84, 0, 0, 0, 0, 0, {2'h3, 4'h0, k[1:0]});
         put(16'hFFFF, 0, 1);
         ph(0);
         while (eclk !== 1) @(posedge clk_sys);
         n = 0;
         c = 0;
         while (eclk === 1 && n < 40) begin
            n++;
            c += tick;
            @(posedge clk_sys);
         end
         chk("e high", 2 + 4 * k, n);
         chk("ticks", n / 2, c);
      end
      complete_run;
   end
endmodule
bind ecs_top ecs_top_properties u_props (.clk_sys, .rstn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rdata, .program_area_select_q, .program_pin_owned_q, .io_pin_owned_q, .e_clock_q,
   .timer_tick_q);
